// File: design/ldsir_pkg.sv
// Purpose: Shared constants for the LED driver status and identity registers
// Assumes: 100 MHz core clock, byte-wide register map
// Notes: Offsets are the register addresses seen by the two-wire host
package ldsir_pkg;
    // Register addresses
    localparam logic [7:0] LDSIR_OFF_LB_TIMER = 8'h0e;
    localparam logic [7:0] LDSIR_OFF_WDT_KICK = 8'h16;
    localparam logic [7:0] LDSIR_OFF_FAULT_ST = 8'h17;
    localparam logic [7:0] LDSIR_OFF_EVENT_ST = 8'h18;
    localparam logic [7:0] LDSIR_OFF_DIE_ID = 8'h1a;
    localparam logic [7:0] LDSIR_OFF_VAR_ID = 8'h1b;
    // Field positions
    localparam int LDSIR_WDT_KICK_BIT = 0;
    localparam int LDSIR_EV_DERATE_BIT = 7;
    localparam int LDSIR_EV_ILIM_BIT = 6;
    // Reset values
    localparam logic [1:0] LDSIR_LB_SEL_RST = 2'h0;
    localparam logic LDSIR_WDT_KICK_RST = 1'b0;
    // Low-battery reset timer codes
    localparam logic [1:0] LDSIR_LB_SEL_250US = 2'h0;
    localparam logic [1:0] LDSIR_LB_SEL_500US = 2'h1;
    // Timing
    localparam int LDSIR_CLK_PERIOD_NS = 10;
    localparam int LDSIR_LB_TIME0_NS = 250000;
    localparam int LDSIR_LB_TIME1_NS = 500000;
    localparam int LDSIR_LB_CYC0 = LDSIR_LB_TIME0_NS / LDSIR_CLK_PERIOD_NS;
    localparam int LDSIR_LB_CYC1 = LDSIR_LB_TIME1_NS / LDSIR_CLK_PERIOD_NS;
    // Serial engine bit count per byte
    localparam logic [3:0] LDSIR_BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LDSIR_LAST_TX_BIT = 4'h7;
endpackage : ldsir_pkg

// File: design/ldsir_line_cond.sv
// Purpose: Edge and bus-condition detect on the two-wire clock and data lines
// Assumes: Line inputs already synchronous to core_clk
// Notes: Pulses are one core_clk wide
`timescale 1ns/10ps
module ldsir_line_cond
    import ldsir_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_rise,
    output logic scl_fall,
    output logic start_det,
    output logic stop_det
);
    // Previous line levels
    typedef struct packed {
        logic scl;
        logic sda;
    } ldsir_line_t;

    ldsir_line_t s_q, s_d;

    // Next state is simply the current line levels
    always_comb begin
        s_d = s_q;
        s_d.scl = scl_in;
        s_d.sda = sda_in;
    end

    // Idle bus is high on both lines
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    // Data moving while the clock is high marks start or stop
    assign scl_rise = scl_in & ~s_q.scl;
    assign scl_fall = ~scl_in & s_q.scl;
    assign start_det = scl_in & s_q.scl & s_q.sda & ~sda_in;
    assign stop_det = scl_in & s_q.scl & ~s_q.sda & sda_in;
endmodule : ldsir_line_cond

// File: design/ldsir_flag_latch.sv
// Purpose: Bank of sticky condition flags cleared by a read
// Assumes: Clear is a one-cycle pulse
// Notes: A live condition always beats the clear
`timescale 1ns/10ps
module ldsir_flag_latch
    import ldsir_pkg::*;
#(
    parameter int W = 8
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [W-1:0] cond,
    input wire logic clr,
    output logic [W-1:0] flags
);
    // Held flags
    typedef struct packed {
        logic [W-1:0] f;
    } ldsir_flags_t;

    ldsir_flags_t s_q, s_d;

    // Set wins over clear so no event is lost
    always_comb begin
        s_d = s_q;
        s_d.f = (s_q.f & ~{W{clr}}) | cond;
    end

    // Flags start empty
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign flags = s_q.f;
endmodule : ldsir_flag_latch

// File: design/ldsir_regs.sv
// Purpose: Status, watchdog kick, timer select and identity registers
// Assumes: Two-wire host, inputs synchronous to core_clk
// Notes: Host reaches registers through a byte-wide serial slave
`timescale 1ns/10ps
module ldsir_regs
    import ldsir_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h4a,
    parameter logic [7:0] DIE_TYPE_BCD = 8'h42, // Arbitrary value
    parameter logic [3:0] DASH_BCD = 4'h0,
    parameter logic [3:0] DIE_REV_BCD = 4'h1, // Arbitrary value
    parameter logic [15:0] LB_CYC0 = 16'(LDSIR_LB_CYC0),
    parameter logic [15:0] LB_CYC1 = 16'(LDSIR_LB_CYC1)
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic thermistor_short,
    input wire logic radio_blank_event,
    input wire logic output_window_fault,
    input wire logic die_over_temp,
    input wire logic thermistor_trip,
    input wire logic indicator_led_fault,
    input wire logic strobe_led_b_fault,
    input wire logic strobe_led_a_fault,
    input wire logic low_batt_derate,
    input wire logic blank_current_limit,
    input wire logic wdt_restarted,
    output logic wdt_restart_req,
    output logic [1:0] low_batt_reset_time_sel,
    output logic [15:0] low_batt_reset_cycles
);
    // Serial engine states
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_ADDR_ACK = 9'h004,
        ST_REG = 9'h008,
        ST_REG_ACK = 9'h010,
        ST_WDATA = 9'h020,
        ST_WDATA_ACK = 9'h040,
        ST_RDATA = 9'h080,
        ST_RDATA_ACK = 9'h100
    } ldsir_state_t;

    // All state of the block
    typedef struct packed {
        ldsir_state_t st;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic rnw;
        logic nack;
        logic [7:0] ptr;
        logic drive_low;
        logic [1:0] lb_sel;
        logic wdt_kick;
        logic [15:0] lb_cyc;
    } ldsir_regs_t;

    ldsir_regs_t s_q, s_d;

    logic scl_rise, scl_fall, start_det, stop_det;
    logic [7:0] fault_flags; // First status register
    logic [1:0] event_flags; // Second status register, bits 7:6
    logic clr_fault; // Read of first status register
    logic clr_event; // Read of second status register
    logic wr_en; // One-cycle byte write strobe
    logic wdt_set; // Host wrote a one to the kick bit
    logic load_rd; // Read byte taken into the shifter

    // Read decode, shared by every read load
    function automatic logic [7:0] rd_mux(input logic [7:0] a, input ldsir_regs_t s,
                                          input logic [7:0] ff, input logic [1:0] ef);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            LDSIR_OFF_LB_TIMER: v = {6'h00, s.lb_sel};
            LDSIR_OFF_WDT_KICK: v = {7'h00, s.wdt_kick};
            LDSIR_OFF_FAULT_ST: v = ff;
            LDSIR_OFF_EVENT_ST: v = {ef, 6'h00};
            LDSIR_OFF_DIE_ID: v = DIE_TYPE_BCD;
            LDSIR_OFF_VAR_ID: v = {DASH_BCD, DIE_REV_BCD};
            default: v = 8'h00;
        endcase
        return v;
    endfunction : rd_mux

    // Bus edges and conditions
    ldsir_line_cond u_line (
        .core_clk(core_clk),
        .nrst(nrst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall),
        .start_det(start_det),
        .stop_det(stop_det)
    );

    // Fault flags, bit order from thermistor short down to strobe LED A
    ldsir_flag_latch #(.W(8)) u_fault (
        .core_clk(core_clk),
        .nrst(nrst),
        .cond({thermistor_short, radio_blank_event, output_window_fault,
               die_over_temp, thermistor_trip, indicator_led_fault,
               strobe_led_b_fault, strobe_led_a_fault}),
        .clr(clr_fault),
        .flags(fault_flags)
    );

    // Event flags since last read
    ldsir_flag_latch #(.W(2)) u_event (
        .core_clk(core_clk),
        .nrst(nrst),
        .cond({low_batt_derate, blank_current_limit}),
        .clr(clr_event),
        .flags(event_flags)
    );

    // Serial engine and register writes
    always_comb begin
        s_d = s_q;
        clr_fault = 1'b0;
        clr_event = 1'b0;
        wr_en = 1'b0;
        load_rd = 1'b0;
        case (s_q.st)
            ST_IDLE: begin
                s_d.drive_low = 1'b0;
            end
            ST_ADDR, ST_REG, ST_WDATA: begin
                // Sample on rising clock, act after the eighth bit
                if (scl_rise) begin
                    s_d.shreg = {s_q.shreg[6:0], sda_in};
                    s_d.bitcnt = s_q.bitcnt + 4'h1;
                end else if (scl_fall && s_q.bitcnt == LDSIR_BITS_PER_BYTE) begin
                    s_d.drive_low = 1'b1;
                    if (s_q.st == ST_ADDR) begin
                        // Only our address is acknowledged
                        s_d.rnw = s_q.shreg[0];
                        s_d.drive_low = (s_q.shreg[7:1] == DEV_ADDR);
                        s_d.st = (s_q.shreg[7:1] == DEV_ADDR) ? ST_ADDR_ACK : ST_IDLE;
                    end else if (s_q.st == ST_REG) begin
                        s_d.ptr = s_q.shreg;
                        s_d.st = ST_REG_ACK;
                    end else begin
                        wr_en = 1'b1;
                        s_d.ptr = s_q.ptr + 8'h01;
                        s_d.st = ST_WDATA_ACK;
                    end
                end
            end
            ST_ADDR_ACK, ST_RDATA_ACK: begin
                // Master acknowledge sampled on the rising clock
                if (scl_rise) begin
                    s_d.nack = sda_in;
                end else if (scl_fall) begin
                    s_d.bitcnt = 4'h0;
                    s_d.drive_low = 1'b0;
                    if (s_q.st == ST_ADDR_ACK && !s_q.rnw) begin
                        s_d.st = ST_REG;
                    end else if (s_q.st == ST_RDATA_ACK && s_q.nack) begin
                        s_d.st = ST_IDLE;
                    end else begin
                        // Snapshot the byte; clear flags it has captured
                        load_rd = 1'b1;
                        s_d.shreg = rd_mux(s_q.ptr, s_q, fault_flags, event_flags);
                        s_d.drive_low = ~s_d.shreg[7];
                        clr_fault = (s_q.ptr == LDSIR_OFF_FAULT_ST);
                        clr_event = (s_q.ptr == LDSIR_OFF_EVENT_ST);
                        s_d.ptr = s_q.ptr + 8'h01;
                        s_d.st = ST_RDATA;
                    end
                end
            end
            ST_REG_ACK, ST_WDATA_ACK: begin
                // Release the line and take the next byte
                if (scl_fall) begin
                    s_d.drive_low = 1'b0;
                    s_d.bitcnt = 4'h0;
                    s_d.st = ST_WDATA;
                end
            end
            ST_RDATA: begin
                // Shift the next bit out on each falling clock
                if (scl_fall) begin
                    if (s_q.bitcnt == LDSIR_LAST_TX_BIT) begin
                        s_d.drive_low = 1'b0;
                        s_d.st = ST_RDATA_ACK;
                    end else begin
                        s_d.shreg = {s_q.shreg[6:0], 1'b0};
                        s_d.drive_low = ~s_q.shreg[6];
                        s_d.bitcnt = s_q.bitcnt + 4'h1;
                    end
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
        // Start and stop override any byte in flight
        if (start_det) begin
            s_d.st = ST_ADDR;
            s_d.bitcnt = 4'h0;
            s_d.drive_low = 1'b0;
        end else if (stop_det) begin
            s_d.st = ST_IDLE;
            s_d.drive_low = 1'b0;
        end
        // Byte write decode; identity and status ignore writes
        wdt_set = wr_en && s_q.ptr == LDSIR_OFF_WDT_KICK
                  && s_q.shreg[LDSIR_WDT_KICK_BIT];
        if (wr_en && s_q.ptr == LDSIR_OFF_LB_TIMER) begin
            s_d.lb_sel = s_q.shreg[1:0];
        end
        // Restart acknowledge clears the kick, a new kick wins
        s_d.wdt_kick = (s_q.wdt_kick & ~wdt_restarted) | wdt_set;
        // Reserved codes fall back to the shorter time
        s_d.lb_cyc = (s_d.lb_sel == LDSIR_LB_SEL_500US) ? LB_CYC1 : LB_CYC0;
    end

    // Single register stage for the whole block
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '{st: ST_IDLE, bitcnt: 4'h0, shreg: 8'h00, rnw: 1'b0, nack: 1'b0,
                     ptr: 8'h00, drive_low: 1'b0, lb_sel: LDSIR_LB_SEL_RST,
                     wdt_kick: LDSIR_WDT_KICK_RST, lb_cyc: LB_CYC0};
        end else begin
            s_q <= s_d;
        end
    end

    // Open-drain data: only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe = s_q.drive_low;
    assign wdt_restart_req = s_q.wdt_kick;
    assign low_batt_reset_time_sel = s_q.lb_sel;
    assign low_batt_reset_cycles = s_q.lb_cyc;

    // Own address fully received on the eighth falling clock
    sequence seq_addr_match;
        s_q.st == ST_ADDR && s_q.bitcnt == LDSIR_BITS_PER_BYTE && scl_fall
        && s_q.shreg[7:1] == DEV_ADDR && !start_det && !stop_det;
    endsequence

    // Fault read load with no live fault condition
    sequence seq_fault_read_quiet;
        clr_fault && ({thermistor_short, radio_blank_event, output_window_fault,
        die_over_temp, thermistor_trip, indicator_led_fault, strobe_led_b_fault,
        strobe_led_a_fault} == 8'h00);
    endsequence

    a_addr_ack_drive: assert property (@(posedge core_clk) disable iff (!nrst)
        seq_addr_match |=> sda_oe && s_q.st == ST_ADDR_ACK)
        else $error("address match not acknowledged");
    a_fault_clear_read: assert property (@(posedge core_clk) disable iff (!nrst)
        seq_fault_read_quiet |=> fault_flags == 8'h00 && s_q.shreg == $past(fault_flags))
        else $error("fault read did not return then clear");
    a_fault_sticky: assert property (@(posedge core_clk) disable iff (!nrst)
        !clr_fault |=> (fault_flags & $past(fault_flags)) == $past(fault_flags))
        else $error("fault flag lost without read");
    a_fault_reset_again: assert property (@(posedge core_clk) disable iff (!nrst)
        clr_fault && thermistor_short |=> fault_flags[7])
        else $error("active fault not set again");
    a_event_capture: assert property (@(posedge core_clk) disable iff (!nrst)
        low_batt_derate |=> event_flags[1] [*1] ##0 (clr_event || event_flags[1]))
        else $error("derate event not latched");
    a_event_rsv_zero: assert property (@(posedge core_clk) disable iff (!nrst)
        load_rd && s_q.ptr == LDSIR_OFF_EVENT_ST |=> s_q.shreg[5:0] == 6'h00)
        else $error("reserved event bits not zero");
    a_id_fixed: assert property (@(posedge core_clk) disable iff (!nrst)
        load_rd && s_q.ptr == LDSIR_OFF_VAR_ID |=> s_q.shreg == {DASH_BCD, DIE_REV_BCD})
        else $error("identity value changed");
    a_wdt_kick_set: assert property (@(posedge core_clk) disable iff (!nrst)
        wdt_set |=> wdt_restart_req)
        else $error("kick write not seen");
    a_wdt_kick_clear: assert property (@(posedge core_clk) disable iff (!nrst)
        wdt_restart_req && wdt_restarted && !wdt_set |=> !wdt_restart_req)
        else $error("kick bit not cleared after restart");
    a_lb_time_map: assert property (@(posedge core_clk) disable iff (!nrst)
        low_batt_reset_time_sel == LDSIR_LB_SEL_500US |-> low_batt_reset_cycles == LB_CYC1)
        else $error("timer count does not match select");

    // Read load of the timer byte; only the select field may be non-zero
    sequence seq_timer_read_load;
        load_rd && s_q.ptr == LDSIR_OFF_LB_TIMER;
    endsequence

    // Read load of the kick byte; only bit 0 may be non-zero
    sequence seq_kick_read_load;
        load_rd && s_q.ptr == LDSIR_OFF_WDT_KICK;
    endsequence

    // Plain falling edge ending a register or data acknowledge clock
    sequence seq_ack_clock_end;
        (s_q.st == ST_REG_ACK || s_q.st == ST_WDATA_ACK) && scl_fall
        && !start_det && !stop_det;
    endsequence

    // Event read load with neither event live, so nothing sets a bit again
    sequence seq_event_read_quiet;
        clr_event && !low_batt_derate && !blank_current_limit;
    endsequence

    // Host write of the timer byte
    sequence seq_timer_write;
        wr_en && s_q.ptr == LDSIR_OFF_LB_TIMER;
    endsequence

    a_timer_rsv_zero: assert property (@(posedge core_clk) disable iff (!nrst)
        seq_timer_read_load |=> s_q.shreg[7:2] == 6'h00)
        else $error("reserved timer bits not zero");
    a_kick_rsv_zero: assert property (@(posedge core_clk) disable iff (!nrst)
        seq_kick_read_load |=> s_q.shreg[7:1] == 7'h00)
        else $error("reserved kick bits not zero");
    a_ack_release: assert property (@(posedge core_clk) disable iff (!nrst)
        seq_ack_clock_end |=> !sda_oe && s_q.st == ST_WDATA)
        else $error("acknowledge not released after its clock");
    a_event_clear_read: assert property (@(posedge core_clk) disable iff (!nrst)
        seq_event_read_quiet |=> event_flags == 2'b00 && s_q.shreg[7:6] == $past(event_flags))
        else $error("event read did not return then clear");
    a_die_type_fixed: assert property (@(posedge core_clk) disable iff (!nrst)
        load_rd && s_q.ptr == LDSIR_OFF_DIE_ID |=> s_q.shreg == DIE_TYPE_BCD)
        else $error("die type value changed");
    a_timer_write_take: assert property (@(posedge core_clk) disable iff (!nrst)
        seq_timer_write |=> low_batt_reset_time_sel == $past(s_q.shreg[1:0]))
        else $error("timer select write not taken");
endmodule : ldsir_regs

// File: sim/ldsir_host_model.sv
// Purpose: Behavioural two-wire host that reaches the register group
// Assumes: Line pulled up when released; quarter bit of four core_clk cycles
// Notes: Changes lines only at falling core_clk edges, so device samples settle
`timescale 1ns/10ps
module ldsir_host_model (
    input wire logic core_clk,
    input wire logic sda_wire,
    output logic scl,
    output logic sda_rel
);
    localparam int QTR = 4; // Quarter bit, twice the two-sample minimum for margin

    // Idle bus: both lines released high
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end

    // Wait whole cycles, always landing on a falling edge
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask : tick

    // Start or repeated start: data falls while clock is high
    task automatic start_cond();
        sda_rel = 1'b1;
        tick(QTR);
        scl = 1'b1;
        tick(QTR);
        sda_rel = 1'b0;
        tick(QTR);
        scl = 1'b0;
        tick(QTR);
    endtask : start_cond

    // Stop: data rises while clock is high, leaving the bus idle
    task automatic stop_cond();
        sda_rel = 1'b0;
        tick(QTR);
        scl = 1'b1;
        tick(QTR);
        sda_rel = 1'b1;
        tick(QTR);
    endtask : stop_cond

    // Eight bits plus acknowledge, MSB first; a one in tx releases the line
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            sda_rel = tx[i];
            tick(QTR);
            scl = 1'b1;
            tick(QTR);
            rx[i] = sda_wire; // Sampled at the end of the high quarter, just before the clock falls
            scl = 1'b0;
            tick(QTR);
        end
    endtask : xfer

    // One byte written at a register pointer; ok only if every byte was acked
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
                             output logic ok);
        logic [8:0] r0;
        logic [8:0] r1;
        logic [8:0] r2;
        start_cond();
        xfer({dev, 1'b0, 1'b1}, r0);
        xfer({a, 1'b1}, r1);
        xfer({d, 1'b1}, r2);
        stop_cond();
        ok = ~(r0[0] | r1[0] | r2[0]);
    endtask : write_reg

    // Pointer set, repeated start, n bytes read; the last is refused by the host
    task automatic read_regs(input logic [6:0] dev, input logic [7:0] a, input int n,
                             output logic [15:0] d, output logic ok);
        logic [8:0] r0;
        logic [8:0] r1;
        logic [8:0] r2;
        logic [8:0] rb;
        d = 16'h0000;
        start_cond();
        xfer({dev, 1'b0, 1'b1}, r0);
        xfer({a, 1'b1}, r1);
        start_cond();
        xfer({dev, 1'b1, 1'b1}, r2);
        for (int i = 1; i <= n; i++) begin
            xfer({8'hff, i == n}, rb);
            d = {d[7:0], rb[8:1]};
        end
        stop_cond();
        ok = ~(r0[0] | r1[0] | r2[0]);
    endtask : read_regs
endmodule : ldsir_host_model

// File: sim/ldsir_tb_top.sv
// Purpose: Self-checking bench for timer select, kick, status and identity registers
// Assumes: Host model owns the two-wire lines; other inputs change at falling edges
// Notes: Timer counts shortened to 5 and 10 cycles to keep the run brief
`timescale 1ns/10ps
module ldsir_tb_top
    import ldsir_pkg::*;
;
    localparam logic [6:0] DEV = 7'h4a; // Address the device answers to
    localparam logic [7:0] DIE_TYPE = 8'h37; // Arbitrary value
    localparam logic [3:0] DIE_REV = 4'h3; // Arbitrary value
    localparam logic [15:0] CYC0 = 16'h0005; // Shortened 0.250 ms count
    localparam logic [15:0] CYC1 = 16'h000a; // Shortened 0.500 ms count
    logic core_clk; // 100 MHz clock
    logic nrst; // Active-low reset
    logic scl; // Host clock line
    logic sda_rel; // Host data, one = released
    logic sda_wire; // Resolved data line
    logic sda_out; // Device data level
    logic sda_oe; // Device pulls data low
    logic [9:0] cond; // Conditions: 9 derate, 8 current limit, 7..0 first status
    logic wdt_done; // Outside watchdog has restarted
    logic wdt_req; // Kick bit
    logic [1:0] sel; // Timer select
    logic [15:0] cycles; // Timer count
    logic ok; // Ack result of a raw access
    logic [7:0] sa; // Status address under test
    int n_mismatch = 0;
    int n_compared = 0;

    // Open drain with pull-up: low if anyone pulls
    assign sda_wire = sda_rel & (sda_oe ? sda_out : 1'b1);

    ldsir_regs #(.DEV_ADDR(DEV), .DIE_TYPE_BCD(DIE_TYPE), .DASH_BCD(4'h0),
        .DIE_REV_BCD(DIE_REV), .LB_CYC0(CYC0), .LB_CYC1(CYC1)) i_dut (
        .core_clk(core_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe(sda_oe), .thermistor_short(cond[7]),
        .radio_blank_event(cond[6]), .output_window_fault(cond[5]), .die_over_temp(cond[4]),
        .thermistor_trip(cond[3]), .indicator_led_fault(cond[2]),
        .strobe_led_b_fault(cond[1]), .strobe_led_a_fault(cond[0]),
        .low_batt_derate(cond[9]), .blank_current_limit(cond[8]), .wdt_restarted(wdt_done),
        .wdt_restart_req(wdt_req), .low_batt_reset_time_sel(sel),
        .low_batt_reset_cycles(cycles));

    ldsir_host_model i_host (.core_clk(core_clk), .sda_wire(sda_wire), .scl(scl),
        .sda_rel(sda_rel));

    // Clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Compare and count
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Acked write to our device
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic wok;
        i_host.write_reg(DEV, a, d, wok);
        check("write ack", 16'h0001, {15'h0, wok});
    endtask : wr

    // Read n bytes and compare
    task automatic rd_chk(input logic [7:0] a, input int n, input logic [15:0] exp);
        logic [15:0] d;
        logic rok;
        i_host.read_regs(DEV, a, n, d, rok);
        check("read ack", 16'h0001, {15'h0, rok});
        check($sformatf("reg %h", a), exp, d);
    endtask : rd_chk

    // Verdict, shared by the tests and the watchdog
    task automatic complete_run();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    // Watchdog, well past the expected 25000 cycles
    initial begin
        repeat (80000) @(posedge core_clk);
        n_mismatch++;
        complete_run();
    end

    // Tests
    initial begin
        nrst = 1'b0;
        cond = 10'h000;
        wdt_done = 1'b0;
        repeat (20) @(negedge core_clk);
        nrst = 1'b1;
        check("sel", 16'h0000, {14'h0, sel});
        check("cycles", CYC0, cycles);
        check("kick", 16'h0000, {15'h0, wdt_req});
        rd_chk(LDSIR_OFF_WDT_KICK, 1, 16'h0000);
        // Every timer code, reserved bits written as ones
        for (int c = 0; c < 4; c++) begin
            wr(LDSIR_OFF_LB_TIMER, 8'hfc | 8'(c));
            rd_chk(LDSIR_OFF_LB_TIMER, 1, 16'(c));
            check("sel", 16'(c), {14'h0, sel});
            check("cycles", (c == 1) ? CYC1 : CYC0, cycles);
        end
        // Kick: zero in bit 0 does nothing, one holds until restart
        wr(LDSIR_OFF_WDT_KICK, 8'hfe);
        check("kick", 16'h0000, {15'h0, wdt_req});
        wr(LDSIR_OFF_WDT_KICK, 8'h01);
        rd_chk(LDSIR_OFF_WDT_KICK, 1, 16'h0001);
        check("kick", 16'h0001, {15'h0, wdt_req});
        wdt_done = 1'b1;
        @(negedge core_clk);
        wdt_done = 1'b0;
        @(negedge core_clk);
        check("kick", 16'h0000, {15'h0, wdt_req});
        rd_chk(LDSIR_OFF_WDT_KICK, 1, 16'h0000);
        // One-cycle condition on each bit in turn: latched, then cleared by read
        for (int b = 0; b < 10; b++) begin
            sa = (b < 8) ? LDSIR_OFF_FAULT_ST : LDSIR_OFF_EVENT_ST;
            cond = 10'(1 << b);
            @(negedge core_clk);
            cond = 10'h000;
            repeat (3) @(negedge core_clk);
            rd_chk(sa, 1, (b < 8) ? 16'(1 << b) : 16'(1 << (b - 2)));
            rd_chk(sa, 1, 16'h0000);
        end
        // Live fault survives the read clear
        cond = 10'h080;
        repeat (2) @(negedge core_clk);
        rd_chk(LDSIR_OFF_FAULT_ST, 1, 16'h0080);
        rd_chk(LDSIR_OFF_FAULT_ST, 1, 16'h0080);
        cond = 10'h000;
        rd_chk(LDSIR_OFF_FAULT_ST, 1, 16'h0080);
        rd_chk(LDSIR_OFF_FAULT_ST, 1, 16'h0000);
        // A read clears only its own register
        cond = 10'h201;
        @(negedge core_clk);
        cond = 10'h000;
        rd_chk(LDSIR_OFF_FAULT_ST, 1, 16'h0001);
        rd_chk(LDSIR_OFF_EVENT_ST, 1, 16'h0080);
        // Status ignores host writes
        wr(LDSIR_OFF_FAULT_ST, 8'hff);
        rd_chk(LDSIR_OFF_FAULT_ST, 1, 16'h0000);
        // Identity pair in one burst, writes ignored
        rd_chk(LDSIR_OFF_DIE_ID, 2, {DIE_TYPE, 4'h0, DIE_REV});
        wr(LDSIR_OFF_DIE_ID, 8'h99);
        wr(LDSIR_OFF_VAR_ID, 8'h99);
        rd_chk(LDSIR_OFF_DIE_ID, 2, {DIE_TYPE, 4'h0, DIE_REV});
        rd_chk(8'h20, 1, 16'h0000);
        // Foreign address refused, timer untouched
        i_host.write_reg(DEV ^ 7'h01, LDSIR_OFF_LB_TIMER, 8'h01, ok);
        check("foreign ack", 16'h0000, {15'h0, ok});
        rd_chk(LDSIR_OFF_LB_TIMER, 1, 16'h0003);
        // Reset in mid-run
        wr(LDSIR_OFF_LB_TIMER, 8'h01);
        wr(LDSIR_OFF_WDT_KICK, 8'h01);
        nrst = 1'b0;
        repeat (2) @(negedge core_clk);
        check("sel", 16'h0000, {14'h0, sel});
        check("cycles", CYC0, cycles);
        check("kick", 16'h0000, {15'h0, wdt_req});
        nrst = 1'b1;
        @(negedge core_clk);
        rd_chk(LDSIR_OFF_DIE_ID, 2, {DIE_TYPE, 4'h0, DIE_REV});
        rd_chk(LDSIR_OFF_LB_TIMER, 1, 16'h0000);
        rd_chk(LDSIR_OFF_WDT_KICK, 1, 16'h0000);
        complete_run();
    end
endmodule : ldsir_tb_top
